// File: src/ssf_status_format.sv
// serial port status flags, smart card format register and avalon slave
// Behaviour
// - async framing error when first stop bit 0
// - framing error stores byte, receive-full stays clear
// - flags clear only by 0 after 1-read or by dma
// - receive disable keeps receive flags unchanged
// - parity error stores byte, halts reception
// - normal transmit end follows last bit, empty
// - received multiprocessor bit captured, kept
// - transmit multiprocessor bit appended per character
// - transmit-empty set on disable or load
// - receive-full set on clean reception
// - overrun keeps old byte, blocks reception
// - smart card error signal low sets flag
// - smart card transmit end after etu delay
// - smart card transmit end cleared by write/dma
// - top mode bit extends clock-pulse select
// - clock-pulse code maps to cycles per bit
// - reserved mode bits read as one
// - msb-first only for eight-bit characters
// - invert data bits, never parity
// - bit zero selects smart card mode
// - format writes only while both directions off
// assumes shifters on ref_clk drive rxEvent, txTake, txLastBit and errWindow
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module ssf_status_format
	import ssf_pkg::*;
(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	// avalon-mm slave
	input  wire logic [4:0]    avsAddress,
	input  wire logic          avsRead,
	input  wire logic          avsWrite,
	input  wire logic [31:0]   avsWriteData,
	input  wire logic [3:0]    avsByteEnable,
	output logic      [31:0]   avsReadData,
	output logic               avsWaitRequest,
	// receive shifter
	input  wire ssf_rx_event_t rxEvent,
	output logic               rxEnable,
	// transmit shifter
	input  wire logic          txTake,
	input  wire logic          txLastBit,
	output logic               txRequest,
	output logic      [7:0]    txData,
	output logic               txMultiprocBit,
	output logic               txEnable,
	// smart card line
	input  wire logic          scLine,
	input  wire logic          errWindow,
	// dma side
	input  wire logic          dmaTxWrite,
	input  wire logic [7:0]    dmaTxData,
	input  wire logic          dmaRxRead,
	// format to shifters
	output logic               smartcardMode,
	output logic               sevenBitChar,
	output logic               syncMode,
	output logic      [9:0]    cyclesPerBit
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ssf_bus_state_t busState_r;
	logic [31:0]    rdData_r;
	logic [7:0]     ctrl_r;
	logic [7:0]     scMode_r;
	logic [7:0]     armed_r;
	logic [7:0]     rdr_r;
	logic [7:0]     tdr_r;
	logic [7:0]     txData_r;
	logic [9:0]     cpb_r;
	logic           transmit_empty_flag_r;
	logic           receive_full_flag_r;
	logic           overrun_flag_r;
	logic           fer_r;
	logic           per_r;
	logic           ers_r;
	logic           transmit_end_flag_r;
	logic           mpbRx_r;
	logic           transmit_multiproc_bit_r;
	logic           lineMeta_r;
	logic           lineSync_r;
	logic           busAck;
	logic           wrStatus;
	logic           rdStatus;
	logic [7:0]     clr;
	logic [7:0]     statusVec;
	logic [31:0]    rdMux;
	logic           te;
	logic           re;
	logic           sc;
	logic           cfgOpen;
	logic           rxHalt;
	logic           txHalt;
	logic           rxAccept;
	logic           frameErr;
	logic           tdreClr;
	logic           etuExpire;
	logic [4:0]     halfEtus;
	logic [7:0]     rxFmt;
	logic [7:0]     txFmt;

	assign te       = ctrl_r[CT_TE];
	assign re       = ctrl_r[CT_RE];
	assign sc       = scMode_r[SC_SMARTCARD_MODE_SELECT];
	assign cfgOpen  = !te && !re;

	// ------------------------------------------------------------
	// avalon slave: one wait cycle, then acknowledge
	// ------------------------------------------------------------
	assign avsWaitRequest = (avsRead || avsWrite) && (busState_r == BUS_IDLE);
	assign busAck         = (avsRead || avsWrite) && (busState_r == BUS_ACK);
	assign avsReadData    = rdData_r;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busState_r <= BUS_IDLE;
		end else begin
			unique case (busState_r)
				BUS_IDLE: if (avsRead || avsWrite) busState_r <= BUS_ACK;
				BUS_ACK:  busState_r <= BUS_IDLE;
			endcase
		end
	end

	always_comb begin
		unique case (avsAddress)
			ADDR_STATUS: rdMux = {24'h000000, statusVec};
			ADDR_SCMODE: rdMux = {24'h000000, scMode_r | SC_RSVD};
			ADDR_CTRL:   rdMux = {24'h000000, ctrl_r};
			ADDR_RXDATA: rdMux = {24'h000000, rdr_r};
			default:     rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= 32'h00000000;
		end else if (avsRead && busState_r == BUS_IDLE) begin
			rdData_r <= rdMux;
		end
	end

	assign rdStatus = busAck && avsRead && avsAddress == ADDR_STATUS;
	assign wrStatus = busAck && avsWrite && avsAddress == ADDR_STATUS && avsByteEnable[0];

	// ------------------------------------------------------------
	// read record and write-zero clears
	// ------------------------------------------------------------
	assign statusVec = {transmit_empty_flag_r, receive_full_flag_r, overrun_flag_r, sc ? ers_r : fer_r, per_r, transmit_end_flag_r, mpbRx_r, transmit_multiproc_bit_r};

	// the record is what software was shown, so a later set is never armed
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_r <= 8'h00;
		end else begin
			armed_r <= (armed_r | (rdStatus ? rdData_r[7:0] & ST_CLEARABLE : 8'h00)) & statusVec;
		end
	end

	assign clr = wrStatus ? (~avsWriteData[7:0] & armed_r) : 8'h00;

	// ------------------------------------------------------------
	// control and smart card mode registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= RST_CTRL;
		end else if (busAck && avsWrite && avsAddress == ADDR_CTRL && avsByteEnable[0]) begin
			if (cfgOpen) begin
				ctrl_r <= avsWriteData[7:0];
			end else begin
				ctrl_r[CT_TE] <= te && avsWriteData[CT_TE];
				ctrl_r[CT_RE] <= re && avsWriteData[CT_RE];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scMode_r <= RST_SCMODE;
		end else if (busAck && avsWrite && avsAddress == ADDR_SCMODE && avsByteEnable[0] && cfgOpen) begin
			scMode_r <= avsWriteData[7:0] & SC_WR_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpb_r <= 10'd0;
		end else begin
			cpb_r <= CYCLES_PER_BIT[{scMode_r[SC_HI], ctrl_r[CT_CLOCK_PULSE_SELECT_LO + 1], ctrl_r[CT_CLOCK_PULSE_SELECT_LO]}];
		end
	end

	assign cyclesPerBit  = cpb_r;
	assign smartcardMode = sc;
	assign sevenBitChar  = ctrl_r[CT_SEVEN];
	assign syncMode      = ctrl_r[CT_SYNC];

	// ------------------------------------------------------------
	// line synchroniser for the error signal
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineMeta_r <= 1'b1;
			lineSync_r <= 1'b1;
		end else begin
			lineMeta_r <= scLine;
			lineSync_r <= lineMeta_r;
		end
	end

	// ------------------------------------------------------------
	// receive path
	// ------------------------------------------------------------
	ssf_bit_format u_rx_fmt (
		.msbFirst (scMode_r[SC_DIR]),
		.sevenBit (ctrl_r[CT_SEVEN]),
		.invert   (scMode_r[SC_INV]),
		.dataIn   (rxEvent.data),
		.dataOut  (rxFmt)
	);

	assign rxHalt   = fer_r || per_r || overrun_flag_r;
	assign rxEnable = re && !rxHalt;
	assign rxAccept = rxEvent.done && rxEnable;
	// the shifter reports only the first stop bit
	assign frameErr = !sc && !syncMode && !rxEvent.stopBit;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdr_r <= 8'h00;
		end else if (rxAccept && !receive_full_flag_r) begin
			rdr_r <= rxFmt;
		end
	end

	// none of the receive flags look at re, so disabling keeps them
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			receive_full_flag_r <= 1'b0;
		end else if (rxAccept && !receive_full_flag_r && !frameErr && !rxEvent.parityErr) begin
			receive_full_flag_r <= 1'b1;
		end else if (clr[ST_RECEIVE_FULL_FLAG] || dmaRxRead) begin
			receive_full_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			overrun_flag_r <= 1'b0;
		end else if (rxAccept && receive_full_flag_r) begin
			overrun_flag_r <= 1'b1;
		end else if (clr[ST_OVERRUN_FLAG]) begin
			overrun_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fer_r <= 1'b0;
		end else if (rxAccept && !receive_full_flag_r && frameErr) begin
			fer_r <= 1'b1;
		end else if (clr[ST_ERR4] && !sc) begin
			fer_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			per_r <= 1'b0;
		end else if (rxAccept && !receive_full_flag_r && !frameErr && rxEvent.parityErr) begin
			per_r <= 1'b1;
		end else if (clr[ST_PER]) begin
			per_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mpbRx_r <= 1'b0;
		end else if (rxAccept) begin
			mpbRx_r <= rxEvent.received_multiproc_bit;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ers_r <= 1'b0;
		end else if (sc && errWindow && !lineSync_r) begin
			ers_r <= 1'b1;
		end else if (clr[ST_ERR4] && sc) begin
			ers_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// transmit path
	// ------------------------------------------------------------
	ssf_bit_format u_tx_fmt (
		.msbFirst (scMode_r[SC_DIR]),
		.sevenBit (ctrl_r[CT_SEVEN]),
		.invert   (scMode_r[SC_INV]),
		.dataIn   (tdr_r),
		.dataOut  (txFmt)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tdr_r <= RST_TXDATA;
		end else if (dmaTxWrite) begin
			tdr_r <= dmaTxData;
		end else if (busAck && avsWrite && avsAddress == ADDR_TXDATA && avsByteEnable[0]) begin
			tdr_r <= avsWriteData[7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txData_r <= 8'h00;
		end else if (txTake) begin
			txData_r <= txFmt;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_multiproc_bit_r <= 1'b0;
		end else if (wrStatus) begin
			transmit_multiproc_bit_r <= avsWriteData[ST_TRANSMIT_MULTIPROC_BIT];
		end
	end

	assign txMultiprocBit = transmit_multiproc_bit_r;
	assign txData         = txData_r;
	assign txHalt         = syncMode && !sc && rxHalt;
	assign txEnable       = te && !txHalt;
	assign txRequest      = txEnable && !transmit_empty_flag_r;
	assign tdreClr        = te && !txTake && (clr[ST_TRANSMIT_EMPTY_FLAG] || dmaTxWrite);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_empty_flag_r <= 1'b1;
		end else if (!te || txTake) begin
			transmit_empty_flag_r <= 1'b1;
		end else if (tdreClr) begin
			transmit_empty_flag_r <= 1'b0;
		end
	end

	assign halfEtus = ctrl_r[CT_GM] ? HALF_GSM : (ctrl_r[CT_BLK] ? HALF_BLOCK : HALF_NORMAL);

	ssf_etu_timer u_etu (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.start        (sc && txTake),
		.halfEtus     (halfEtus),
		.cyclesPerBit (cpb_r),
		.expire       (etuExpire)
	);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_end_flag_r <= 1'b1;
		end else if (!te) begin
			transmit_end_flag_r <= 1'b1;
		end else if (sc) begin
			if (etuExpire && !ers_r && transmit_empty_flag_r) begin
				transmit_end_flag_r <= 1'b1;
			end else if (clr[ST_TRANSMIT_END_FLAG] || dmaTxWrite) begin
				transmit_end_flag_r <= 1'b0;
			end
		end else if (txLastBit && transmit_empty_flag_r) begin
			transmit_end_flag_r <= 1'b1;
		end else if (tdreClr) begin
			transmit_end_flag_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence reqWait;
		(avsRead || avsWrite) && busState_r == BUS_IDLE ##0 avsWaitRequest;
	endsequence
	sequence reqDone;
		!avsWaitRequest ##0 busAck;
	endsequence

	AST_BUS_ONE_WAIT: assert property (reqWait |=> reqDone)
		else $error("bus request not acknowledged after one wait cycle");
	AST_FRAME_ERR: assert property (rxAccept && !receive_full_flag_r && frameErr |=> fer_r && !receive_full_flag_r && rdr_r == $past(rxFmt))
		else $error("framing error did not store byte with receive-full clear");
	AST_HALT_RX: assert property (rxHalt && rxEvent.done |=> $stable(rdr_r) && $stable(mpbRx_r))
		else $error("reception allowed while an error flag is set");
	AST_NO_BLIND_CLR: assert property (wrStatus && !armed_r[ST_RECEIVE_FULL_FLAG] && receive_full_flag_r && !dmaRxRead |=> receive_full_flag_r)
		else $error("receive-full cleared without prior read");
	AST_RE_OFF_KEEP: assert property ($fell(re) && !$past(dmaRxRead) && $past(clr) == 8'h00
		|-> $stable({fer_r, per_r, overrun_flag_r, receive_full_flag_r}))
		else $error("receive flags changed when receive disabled");
	AST_OVERRUN_KEEP: assert property (rxAccept && receive_full_flag_r |=> overrun_flag_r && $stable(rdr_r))
		else $error("overrun did not keep the older byte");
	AST_TRANSMIT_EMPTY_FLAG_OFF: assert property (!te |=> transmit_empty_flag_r ##0 transmit_end_flag_r)
		else $error("empty or end flag low while transmit disabled");
	AST_SC_TRANSMIT_END_FLAG: assert property (te && sc && etuExpire && !ers_r && transmit_empty_flag_r |=> transmit_end_flag_r)
		else $error("smart card transmit end not set after delay");
	AST_CFG_LOCK: assert property (!cfgOpen && busAck && avsWrite && avsAddress == ADDR_SCMODE
		|=> $stable(scMode_r))
		else $error("smart card mode changed while a direction is enabled");
	AST_TAKE_SETS_TRANSMIT_EMPTY_FLAG: assert property (txTake |=> transmit_empty_flag_r && txData_r == $past(txFmt))
		else $error("transmit load did not set empty flag or data");
endmodule

// File: src/ssf_pkg.sv
// package: offsets, field positions, reset values and types of the serial status/format block
// assumes byte addressing on a 32-bit avalon slave port, one register per aligned word
package ssf_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_STATUS = 5'h00;
	localparam logic [4:0] ADDR_SCMODE = 5'h04;
	localparam logic [4:0] ADDR_CTRL   = 5'h08;
	localparam logic [4:0] ADDR_RXDATA = 5'h0c;
	localparam logic [4:0] ADDR_TXDATA = 5'h10;
	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int ST_TRANSMIT_EMPTY_FLAG = 7;
	localparam int ST_RECEIVE_FULL_FLAG = 6;
	localparam int ST_OVERRUN_FLAG = 5;
	localparam int ST_ERR4 = 4;
	localparam int ST_PER  = 3;
	localparam int ST_TRANSMIT_END_FLAG = 2;
	localparam int ST_MPB  = 1;
	localparam int ST_TRANSMIT_MULTIPROC_BIT = 0;
	localparam logic [7:0] ST_CLEARABLE = 8'hfc;
	// ------------------------------------------------------------
	// control and smart card mode fields
	// ------------------------------------------------------------
	localparam int CT_TE    = 0;
	localparam int CT_RE    = 1;
	localparam int CT_SYNC  = 2;
	localparam int CT_SEVEN = 3;
	localparam int CT_GM    = 4;
	localparam int CT_BLK   = 5;
	localparam int CT_CLOCK_PULSE_SELECT_LO  = 6;
	localparam int SC_HI    = 7;
	localparam int SC_DIR   = 3;
	localparam int SC_INV   = 2;
	localparam int SC_SMARTCARD_MODE_SELECT  = 0;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [7:0] RST_SCMODE  = 8'h80;
	localparam logic [7:0] SC_RSVD     = 8'h72;
	localparam logic [7:0] SC_WR_MASK  = 8'h8d;
	localparam logic [7:0] RST_TXDATA  = 8'hff;
	// ------------------------------------------------------------
	// transmit-end delays in etu, counted in half etu
	// ------------------------------------------------------------
	localparam real ETU_NORMAL = 12.5;
	localparam real ETU_BLOCK  = 11.5;
	localparam real ETU_GSM    = 11.0;
	localparam logic [4:0] HALF_NORMAL = 5'(int'(ETU_NORMAL * 2.0));
	localparam logic [4:0] HALF_BLOCK  = 5'(int'(ETU_BLOCK * 2.0));
	localparam logic [4:0] HALF_GSM    = 5'(int'(ETU_GSM * 2.0));
	localparam logic [9:0] CYCLES_PER_BIT [8] = '{10'd93, 10'd128, 10'd186, 10'd512,
		10'd32, 10'd64, 10'd372, 10'd256};
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       done;
		logic [7:0] data;
		logic       stopBit;
		logic       parityErr;
		logic       received_multiproc_bit;
	} ssf_rx_event_t;
	typedef enum logic {BUS_IDLE, BUS_ACK} ssf_bus_state_t;
endpackage

// File: src/ssf_bit_format.sv
// bit order and data inversion between a data register and a shifter
// assumes the same mapping serves both directions
`timescale 1ns/1ps
module ssf_bit_format
	import ssf_pkg::*;
(
	// control
	input  wire logic       msbFirst,
	input  wire logic       sevenBit,
	input  wire logic       invert,
	// data
	input  wire logic [7:0] dataIn,
	output logic      [7:0] dataOut
);
	logic [7:0] ordered;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// seven-bit characters stay lsb-first
			assign ordered[i] = (msbFirst && !sevenBit) ? dataIn[7 - i] : dataIn[i];
			// parity is produced elsewhere, so only data bits flip
			assign dataOut[i] = (sevenBit && i == 7) ? 1'b0 : ordered[i] ^ invert;
		end
	endgenerate
endmodule

// File: src/ssf_etu_timer.sv
// one-shot delay timer in half-etu steps for smart card transmit end
// assumes one basic clock per ref_clk cycle
`timescale 1ns/1ps
module ssf_etu_timer
	import ssf_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       start,
	input  wire logic [4:0] halfEtus,
	input  wire logic [9:0] cyclesPerBit,
	// result
	output logic            expire
);
	logic [14:0] count_r;
	logic        run_r;
	logic [14:0] target;
	logic [14:0] product;

	// both factors widened first so the largest delay does not wrap
	assign product = 15'(halfEtus) * 15'(cyclesPerBit);
	assign target  = product >> 1;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 15'h0000;
			run_r   <= 1'b0;
		end else if (start) begin
			count_r <= 15'h0001;
			run_r   <= 1'b1;
		end else if (run_r) begin
			count_r <= count_r + 15'h0001;
			run_r   <= (count_r != target);
		end
	end

	assign expire = run_r && (count_r == target);
endmodule

// File: testbench/ssf_far_model.sv
// far-side model: receive and transmit shifters and the smart card line
// assumes the bench commands each received character through rxGo and rxCmd
`timescale 1ns/1ps
module ssf_far_model
	import ssf_pkg::*;
(
	// clock
	input  wire logic          ref_clk,
	// commands from the bench
	input  wire logic          rxGo,
	input  wire ssf_rx_event_t rxCmd,
	input  wire logic          lineLow,
	input  wire logic          slow,
	// design side
	input  wire logic          txRequest,
	output ssf_rx_event_t      rxEvent,
	output logic               txTake,
	output logic               txLastBit,
	output logic               scLine,
	output logic               errWindow
);
	int cnt;

	initial begin
		rxEvent = '0;
		txTake = 1'b0;
		txLastBit = 1'b0;
		errWindow = 1'b0;
		cnt = 0;
	end
	// line has a pull-up: high unless the card pulls it low
	assign scLine = ~lineLow;
	// idle data fields toggle so that nothing stale looks valid
	always @(posedge ref_clk) begin
		// delivers even while the port halts reception, so the refusal is exercised
		rxEvent <= rxGo ? rxCmd : {1'b0, ~rxEvent[10:0]};
		txTake <= txRequest && cnt == 0 && !txTake && !slow;
		txLastBit <= cnt == 2;
		errWindow <= cnt > 3 && cnt < 12;
		if (txTake)
			cnt <= 20;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule

// File: testbench/ssf_status_format_bench.sv
// self-checking bench of the serial status and format block
// assumes the far-side model ssf_far_model and one clock domain
`timescale 1ns/1ps
module ssf_status_format_bench
	import ssf_pkg::*;
;
	logic          ref_clk = 0, rst_n = 0, avsRead = 0, avsWrite = 0;
	logic          dmaTxWrite = 0, dmaRxRead = 0, rxGo = 0, lineLow = 0;
	logic          slow = 0, takeSeen = 0, msb = 0, inv = 0, sev = 0;
	logic [4:0]    avsAddress = '0;
	logic [31:0]   avsWriteData = '0, avsReadData, lfsr = 32'hc8de;
	logic [7:0]    dmaTxData = '0, txData, d;
	logic [9:0]    cyclesPerBit;
	logic          avsWaitRequest, rxEnable, txTake, txLastBit, txRequest;
	logic          txMultiprocBit, txEnable, scLine, errWindow;
	logic          smartcardMode, sevenBitChar, syncMode;
	ssf_rx_event_t rxEvent, rxCmd = '0;
	logic [7:0]    rdQ[$];
	logic [8:0]    txQ[$];
	int            err_count = 0, checks = 0;
	localparam logic [9:0] CPB [8] = '{10'd93, 10'd128, 10'd186, 10'd512,
		10'd32, 10'd64, 10'd372, 10'd256};
	localparam logic [7:0] SCT [3] = '{8'h01, 8'h21, 8'h11};
	localparam int         DLY [3] = '{400, 368, 352};

	initial forever #2.5 ref_clk = ~ref_clk;

	ssf_status_format i_dut (.ref_clk, .rst_n, .avsAddress, .avsRead, .avsWrite,
		.avsWriteData, .avsByteEnable(4'h1), .avsReadData, .avsWaitRequest, .rxEvent,
		.rxEnable, .txTake, .txLastBit, .txRequest, .txData, .txMultiprocBit, .txEnable,
		.scLine, .errWindow, .dmaTxWrite, .dmaTxData, .dmaRxRead, .smartcardMode,
		.sevenBitChar, .syncMode, .cyclesPerBit);
	ssf_far_model i_far (.ref_clk, .rxGo, .rxCmd, .lineLow, .slow, .txRequest,
		.rxEvent, .txTake, .txLastBit, .scLine, .errWindow);

	// ------------------------------------------------------------
	// checking
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] fmt(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++)
			r[i] = (msb && !sev) ? v[7-i] : v[i];
		r = inv ? ~r : r;
		return sev ? {1'b0, r[6:0]} : r;
	endfunction
	task automatic test_done();
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic judge(input bit ok, input string m);
		checks++;
		if (!ok) begin
			err_count++;
			$display("ERROR %0t: %s mismatch", $time, m);
		end
	endtask
	task automatic cmpRd(input logic [7:0] e, g);
		judge(e === g, "read data");
	endtask
	task automatic cmpTx(input logic [8:0] e, g);
		judge(e === g, "transmit data");
	endtask
	task automatic cmpCpb(input logic [9:0] e, g);
		judge(e === g, "bit period");
	endtask
	// results are taken off the queues as they appear
	always @(posedge ref_clk) begin
		if (avsRead === 1'b1 && avsWaitRequest === 1'b0)
			cmpRd(rdQ.pop_front(), avsReadData[7:0]);
		if (takeSeen === 1'b1)
			cmpTx(txQ.pop_front(), {txMultiprocBit, txData});
		takeSeen <= txTake;
		lfsr <= lfsrNext(lfsr);
		slow <= lfsr[5];
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic bus(input logic isWr, input logic [4:0] a, input logic [7:0] v);
		avsAddress <= a;
		avsWriteData <= {24'h0, v};
		avsWrite <= isWr;
		avsRead <= !isWr;
		// waitrequest is looked at on the rising edge only
		do
			@(posedge ref_clk);
		while (avsWaitRequest !== 1'b0);
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		bus(1'b1, a, v);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		rdQ.push_back(e);
		bus(1'b0, a, 8'h00);
	endtask
	task automatic deliver(input logic [7:0] v, input logic stp, par, mp);
		rxCmd <= '{1'b1, v, stp, par, mp};
		rxGo <= 1'b1;
		@(posedge ref_clk);
		rxGo <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	// load one byte, by bus with flag clear or by dma, and wait for the take
	task automatic send(input logic [7:0] v, st, clr, input logic dma);
		int n;
		txQ.push_back({clr[0], fmt(v)});
		if (dma) begin
			dmaTxData <= v;
			dmaTxWrite <= 1'b1;
			@(posedge ref_clk);
			dmaTxWrite <= 1'b0;
		end else begin
			wr(ADDR_TXDATA, v);
			rd(ADDR_STATUS, st);
			wr(ADDR_STATUS, clr);
		end
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (txTake !== 1'b1 && n < 300);
		judge(n < 300, "take");
		@(posedge ref_clk);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		test_done();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_STATUS, 8'h84);
		rd(ADDR_SCMODE, 8'hf2);
		rd(ADDR_CTRL, 8'h00);
		rd(5'h14, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_SCMODE, {c[2], 7'h00});
			wr(ADDR_CTRL, {c[1:0], 6'h00});
			rd(ADDR_SCMODE, {c[2], 7'h72});
			cmpCpb(CPB[c], cyclesPerBit);
		end
		wr(ADDR_CTRL, 8'h02);
		wr(ADDR_SCMODE, 8'h81);
		rd(ADDR_SCMODE, 8'hf2);
		d = lfsr[7:0];
		deliver(d, 1'b1, 1'b0, 1'b1);
		rd(ADDR_STATUS, 8'hc6);
		deliver(~d, 1'b1, 1'b0, 1'b0);
		deliver(8'h5a, 1'b1, 1'b0, 1'b1);
		judge(rxEnable === 1'b0, "receive halt");
		rd(ADDR_STATUS, 8'he4);
		rd(ADDR_RXDATA, d);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, 8'h84);
		deliver(d, 1'b1, 1'b0, 1'b1);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, 8'hc6);
		dmaRxRead <= 1'b1;
		@(posedge ref_clk);
		dmaRxRead <= 1'b0;
		rd(ADDR_STATUS, 8'h86);
		deliver(~d, 1'b0, 1'b1, 1'b0);
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, 8'h94);
		rd(ADDR_RXDATA, ~d);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_STATUS, 8'h94);
		wr(ADDR_STATUS, 8'hef);
		rd(ADDR_STATUS, 8'h85);
		wr(ADDR_CTRL, 8'h02);
		deliver(d, 1'b1, 1'b1, 1'b1);
		rd(ADDR_STATUS, 8'h8f);
		rd(ADDR_RXDATA, d);
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_CTRL, 8'h00);
		// format is set before either direction is enabled
		wr(ADDR_SCMODE, 8'h8c);
		rd(ADDR_SCMODE, 8'hfe);
		wr(ADDR_CTRL, 8'h01);
		msb = 1'b1;
		inv = 1'b1;
		send(lfsr[7:0], 8'h87, 8'h01, 1'b0);
		repeat (30) @(posedge ref_clk);
		rd(ADDR_STATUS, 8'h87);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h09);
		sev = 1'b1;
		judge(sevenBitChar === 1'b1 && txEnable === 1'b1, "format");
		send(lfsr[7:0], 8'h87, 8'h01, 1'b1);
		rd(ADDR_STATUS, 8'h83);
		repeat (30) @(posedge ref_clk);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_SCMODE, 8'h81);
		judge(smartcardMode === 1'b1 && syncMode === 1'b0, "mode");
		wr(ADDR_STATUS, 8'h00);
		msb = 1'b0;
		sev = 1'b0;
		inv = 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL, 8'h00);
			wr(ADDR_CTRL, SCT[i]);
			send(lfsr[7:0], 8'h86, 8'h00, 1'b0);
			repeat (DLY[i] - 30) @(posedge ref_clk);
			rd(ADDR_STATUS, 8'h82);
			repeat (50) @(posedge ref_clk);
			rd(ADDR_STATUS, 8'h86);
		end
		lineLow <= 1'b1;
		send(lfsr[7:0], 8'h86, 8'h00, 1'b0);
		repeat (30) @(posedge ref_clk);
		rd(ADDR_STATUS, 8'h92);
		repeat (420) @(posedge ref_clk);
		rd(ADDR_STATUS, 8'h92);
		lineLow <= 1'b0;
		wr(ADDR_STATUS, 8'h80);
		rd(ADDR_STATUS, 8'h82);
		@(posedge ref_clk);
		test_done();
	end
endmodule
